// ===== bench/ifp_i2c_master.sv
// I2C master model acting as the device programmer
module ifp_i2c_master (
  input  wire logic clock,
  input  wire logic sclOe,
  input  wire logic sdaOe,
  output wire logic sclIn,
  output wire logic sdaIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic mScl = 1'b1;
  logic mSda = 1'b1;
  int   waitCnt;
  // Open-drain lines with pull-ups
  assign sclIn = mScl & ~sclOe;
  assign sdaIn = mSda & ~sdaOe;
  task automatic half();
    repeat (4) @(negedge clock);
  endtask
  // Release SCL and wait out a device hold
  task automatic rise();
    mScl = 1'b1;
    waitCnt = 0;
    while (!sclIn && waitCnt < 70000)
    begin
      @(negedge clock);
      waitCnt++;
    end
    half();
  endtask
  task automatic start();
    mSda = 1'b1;
    half();
    rise();
    mSda = 1'b0;
    half();
    mScl = 1'b0;
  endtask
  task automatic stop();
    mSda = 1'b0;
    half();
    rise();
    mSda = 1'b1;
    half();
  endtask
  task automatic sendByte(logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      mSda = d[i];
      half();
      rise();
      mScl = 1'b0;
    end
    mSda = 1'b1;
    half();
    mScl = 1'b1;
    repeat (2) @(negedge clock);
    ack = ~sdaIn;
    repeat (2) @(negedge clock);
    mScl = 1'b0;
  endtask
endmodule // ifp_i2c_master

// ===== bench/ifp_seq_bench.sv
// Self-checking bench for the programming sequencer
`include "ifp_map.vh"
module ifp_seq_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TE  = 100;
  localparam int TW  = 120;
  localparam int TEW = 200;
  typedef struct {
    logic [7:0] cmd; int n; logic [7:0] a1; logic [7:0] a2; logic ack;
    logic [1:0] kind; logic wr; logic [15:0] addr; logic [15:0] mask;
    int hold;
  } ifp_row_t;
  logic        clock = 1'b0;
  logic        rstn;
  logic        sclIn, sclOe, sdaIn, sdaOe, nvmErase, nvmWr, lockClr;
  logic        busy, modeActive, a;
  logic        sclOut, sdaOut;
  logic [1:0]  nvmEraseKind;
  logic [15:0] nvmAddr;
  logic [7:0]  nvmWdata;
  logic [15:0] wrAddrQ[$];
  logic [7:0]  wrDataQ[$];
  logic [17:0] erQ[$];
  int          errCount = 0;
  int          checked = 0;
  int          lockCnt, holdCnt, holdLen;
  ifp_row_t    rows[6] = '{
    '{`IFP_CMD_SEL_PG, 1, 8'h05, 8'h00, 1, 2'h3, 0, 16'h0, 16'h0, 0},
    '{`IFP_CMD_BYTE_PR, 2, 8'h47, 8'h5A, 1, 2'h2, 1, 16'h0547, 16'hFFFF, TEW},
    '{`IFP_CMD_BYT_CLR, 1, 8'h21, 8'h00, 1, 2'h2, 0, 16'h0521, 16'hFFFF, TE},
    '{`IFP_CMD_BLK_CLR, 1, 8'hE5, 8'h00, 1, 2'h1, 0, 16'h05E0, 16'hFFE0, TE},
    '{`IFP_CMD_ALL_CLR, 0, 8'h00, 8'h00, 1, 2'h0, 0, 16'h0, 16'h0, TE},
    '{8'h05, 0, 8'h00, 8'h00, 0, 2'h3, 0, 16'h0, 16'h0, 0}};
  // Free-running 100 ns system clock
  initial
  begin
    forever #50 clock = ~clock;
  end
  ifp_seq #(.T_ERASE_CYC(TE), .T_WRITE_CYC(TW), .T_ERWR_CYC(TEW)) u_dut (
    .clock(clock), .rstn(rstn), .sclIn(sclIn), .sclOut(sclOut),
    .sclOe(sclOe), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .nvmErase(nvmErase),
    .nvmEraseKind(nvmEraseKind), .nvmWr(nvmWr), .nvmAddr(nvmAddr),
    .nvmWdata(nvmWdata), .lockClr(lockClr), .busy(busy),
    .modeActive(modeActive));
  ifp_i2c_master u_mst (.clock(clock), .sclOe(sclOe), .sdaOe(sdaOe),
    .sclIn(sclIn), .sdaIn(sdaIn));
  // Memory port log and hold length
  always @(posedge clock)
  begin
    if (nvmWr)
    begin
      wrAddrQ.push_back(nvmAddr);
      wrDataQ.push_back(nvmWdata);
    end
    if (nvmErase)
      erQ.push_back({nvmEraseKind, nvmAddr});
    if (lockClr)
      lockCnt++;
    if (sclOe)
      holdCnt++;
    else if (holdCnt != 0)
    begin
      holdLen = holdCnt;
      holdCnt = 0;
    end
  end
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errCount++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic testDone();
    $display("Comparisons %0d, mismatches %0d", checked, errCount);
    if (errCount == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic clr();
    erQ.delete();
    wrAddrQ.delete();
    wrDataQ.delete();
    lockCnt = 0;
  endtask
  task automatic waitOp(int h);
    int n;
    n = 0;
    repeat (6) @(negedge clock);
    while (sclOe !== 1'b0 && n < 70000)
    begin
      @(negedge clock);
      n++;
    end
    repeat (2) @(negedge clock);
    chk(holdLen >= h && holdLen <= h + 5, 1);
  endtask
  task automatic doCmd(logic [7:0] c, int n, logic [7:0] x, logic [7:0] y,
                       logic ak);
    u_mst.sendByte(c, a);
    chk(a, ak);
    if (n > 0)
    begin
      u_mst.sendByte(x, a);
      chk(a, 1'b1);
    end
    if (n > 1)
    begin
      u_mst.sendByte(y, a);
      chk(a, 1'b1);
    end
  endtask
  task automatic adv(int n);
    repeat (n) doCmd(`IFP_CMD_ADV_BLK, 0, 8'h00, 8'h00, 1'b1);
  endtask
  task automatic blkProg(logic [7:0] c, logic [10:0] pb, int h);
    clr();
    doCmd(c, 0, 8'h00, 8'h00, 1'b1);
    for (int i = 0; i < 32; i++)
    begin
      u_mst.sendByte(8'(i) ^ 8'hA5, a);
      chk(a, 1'b1);
    end
    waitOp(h);
    chk(wrAddrQ.size(), 32);
    for (int i = 0; i < wrAddrQ.size() && i < 32; i++)
      chk({wrAddrQ[i], wrDataQ[i]}, {pb, 5'(i), 8'(i) ^ 8'hA5});
    chk(erQ.size(), c == `IFP_CMD_BLK_ERW);
    if (erQ.size() > 0)
      chk(erQ[0][17:5], {`IFP_KIND_BLOCK, pb});
  endtask
  // Hang guard
  initial
  begin
    #6000000;
    errCount++;
    testDone();
  end
  initial
  begin
    rstn = 1'b0;
    repeat (20) @(negedge clock);
    chk({sclOe, sdaOe, busy, modeActive, sclOut, sdaOut}, 6'h00);
    rstn = 1'b1;
    repeat (4) @(negedge clock);
    u_mst.start();
    u_mst.sendByte(`IFP_SLV_WR, a);
    chk(a, 1'b1);
    u_mst.sendByte(`IFP_MODE_CODE, a);
    chk(a, 1'b1);
    chk(modeActive, 1'b1);
    foreach (rows[i])
    begin
      clr();
      doCmd(rows[i].cmd, rows[i].n, rows[i].a1, rows[i].a2, rows[i].ack);
      if (rows[i].kind != 2'h3)
        waitOp(rows[i].hold);
      chk(erQ.size(), rows[i].kind != 2'h3);
      if (erQ.size() > 0)
        chk({erQ[0][17:16], erQ[0][15:0] & rows[i].mask},
            {rows[i].kind, rows[i].addr});
      chk(wrAddrQ.size(), rows[i].wr);
      if (wrAddrQ.size() > 0)
        chk(wrDataQ[0], rows[i].a2);
      chk(lockCnt, rows[i].kind == 2'h0);
    end
    // Wrong direction refused, new session skips mode code
    u_mst.stop();
    u_mst.start();
    u_mst.sendByte(8'hA1, a);
    chk(a, 1'b0);
    u_mst.start();
    u_mst.sendByte(`IFP_SLV_WR, a);
    chk(a, 1'b1);
    // reach block 7 of page 31
    doCmd(`IFP_CMD_SEL_PG, 1, 8'h1F, 8'h00, 1'b1);
    adv(7);
    blkProg(`IFP_CMD_BLK_NER, {8'h1F, 3'h7}, TW);
    adv(1);
    clr();
    doCmd(`IFP_CMD_BYT_CLR, 1, 8'h00, 8'h00, 1'b1);
    waitOp(TE);
    chk(erQ.size() > 0 ? erQ[0] : 18'h3FFFF, 18'h20000);
    doCmd(`IFP_CMD_SEL_PG, 1, 8'h02, 8'h00, 1'b1);
    adv(8);
    clr();
    doCmd(`IFP_CMD_BLK_CLR, 1, 8'h00, 8'h00, 1'b1);
    waitOp(TE);
    chk(erQ.size() > 0 ? erQ[0][17:5] : 13'h1FFF, 13'h0818);
    doCmd(`IFP_CMD_SEL_PG, 1, `IFP_RST_PAGE, 8'h00, 1'b1);
    blkProg(`IFP_CMD_BLK_ERW, {`IFP_RST_PAGE, 3'h0}, TEW);
    // Reset mid-run drops mode, pointers back to lock block
    u_mst.stop();
    rstn = 1'b0;
    repeat (2) @(negedge clock);
    chk({sclOe, sdaOe, busy, modeActive, sclOut, sdaOut}, 6'h00);
    rstn = 1'b1;
    repeat (4) @(negedge clock);
    u_mst.start();
    u_mst.sendByte(`IFP_SLV_WR, a);
    chk(a, 1'b1);
    chk(modeActive, 1'b0);
    u_mst.sendByte(`IFP_MODE_CODE, a);
    chk(a, 1'b1);
    blkProg(`IFP_CMD_BLK_NER, {`IFP_RST_PAGE, `IFP_RST_BLOCK}, TW);
    u_mst.stop();
    testDone();
  end
endmodule // ifp_seq_bench

// ===== bench/ifp_seq_checker.sv
// Port-level checks for the programming sequencer
`include "ifp_map.vh"
module ifp_seq_checker #(
  parameter T_ERASE_CYC = 100,
  parameter T_ERWR_CYC  = 200
) (
  input wire       clock,
  input wire       rstn,
  input wire       sclOe,
  input wire       sdaOe,
  input wire       nvmErase,
  input wire [1:0] nvmEraseKind,
  input wire       nvmWr,
  input wire       lockClr,
  input wire       busy,
  input wire       modeActive
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [16:0] holdCnt;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // Length of the current clock hold
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      holdCnt <= 17'h00000;
    else if (sclOe)
      holdCnt <= holdCnt + 17'h00001;
    else
      holdCnt <= 17'h00000;
  no_ack_busy_a:
    assert property (busy |-> !sdaOe) else $error("ack while busy");
  hold_at_busy_a:
    assert property ($rose(busy) |-> sclOe) else $error("busy without hold");
  busy_release_a:
    assert property ($fell(sclOe) |-> ##[0:2] !busy)
    else $error("busy after release");
  erase_in_hold_a:
    assert property (nvmErase |-> sclOe) else $error("erase outside hold");
  write_in_hold_a:
    assert property (nvmWr |-> sclOe) else $error("write outside hold");
  lock_with_all_a:
    assert property (lockClr |-> nvmErase && nvmEraseKind == `IFP_KIND_ALL)
    else $error("lock clear without erase-all");
  all_clears_lock_a:
    assert property (nvmErase && nvmEraseKind == `IFP_KIND_ALL |-> lockClr)
    else $error("erase-all kept lock");
  lock_pulse_a:
    assert property (lockClr |=> !lockClr) else $error("lock clear too long");
  hold_min_a:
    assert property ($fell(sclOe) |-> holdCnt >= T_ERASE_CYC)
    else $error("hold too short");
  hold_max_a:
    assert property (holdCnt <= T_ERWR_CYC + 8) else $error("hold too long");
  mode_first_a:
    assert property (!modeActive |-> !sclOe) else $error("hold before entry");
  kind_legal_a:
    assert property (nvmErase |-> nvmEraseKind != 2'h3)
    else $error("bad erase kind");
endmodule // ifp_seq_checker

bind ifp_seq ifp_seq_checker #(
  .T_ERASE_CYC(T_ERASE_CYC),
  .T_ERWR_CYC (T_ERWR_CYC)
) u_chk (
  .clock       (clock),
  .rstn        (rstn),
  .sclOe       (sclOe),
  .sdaOe       (sdaOe),
  .nvmErase    (nvmErase),
  .nvmEraseKind(nvmEraseKind),
  .nvmWr       (nvmWr),
  .lockClr     (lockClr),
  .busy        (busy),
  .modeActive  (modeActive)
);

// ===== logic/ifp_buf.v
// Block data buffer with registered read port
module ifp_buf #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clock,
  input  wire             we,
  input  wire [AW-1:0]    wrAddr,
  input  wire [WIDTH-1:0] wrData,
  input  wire [AW-1:0]    rdAddr,
  output reg  [WIDTH-1:0] rdData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // Write port and registered read
  always @(posedge clock)
  begin
    if (we)
      mem[wrAddr] <= wrData;
    rdData <= mem[rdAddr];
  end
endmodule // ifp_buf

// ===== logic/ifp_i2c_rx.v
// I2C slave receiver: bytes, acknowledge slot and clock hold
module ifp_i2c_rx (
  input  wire       clock,
  input  wire       rstn,
  input  wire       sclIn,
  input  wire       sdaIn,
  input  wire       ackReq,
  input  wire       holdReq,
  input  wire       holdRel,
  output reg        sdaOe,
  output reg        sclOe,
  output reg        byteStb,
  output reg  [7:0] byteData,
  output reg        firstByte,
  output reg        ackDone,
  output reg        startStb,
  output reg        stopStb
);
  reg       sclS1_r;
  reg       sclS2_r;
  reg       sclS3_r;
  reg       sdaS1_r;
  reg       sdaS2_r;
  reg       sdaS3_r;
  reg [3:0] bitCnt_r;
  reg       ackPh_r;
  reg       inFirst_r;
  wire      sclRise = sclS2_r & ~sclS3_r;
  wire      sclFall = ~sclS2_r & sclS3_r;
  wire      sclHigh = sclS2_r & sclS3_r;
  wire      isStart = sclHigh & ~sdaS2_r & sdaS3_r;
  wire      isStop  = sclHigh & sdaS2_r & ~sdaS3_r;

  // Two-stage synchronisers plus an edge stage
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      {sclS1_r, sclS2_r, sclS3_r} <= 3'h7;
      {sdaS1_r, sdaS2_r, sdaS3_r} <= 3'h7;
    end
    else
    begin
      {sclS1_r, sclS2_r, sclS3_r} <= {sclIn, sclS1_r, sclS2_r};
      {sdaS1_r, sdaS2_r, sdaS3_r} <= {sdaIn, sdaS1_r, sdaS2_r};
    end
  end

  // Bit shifting, acknowledge drive and SCL hold
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      bitCnt_r  <= 4'h0;
      ackPh_r   <= 1'b0;
      inFirst_r <= 1'b0;
      sdaOe     <= 1'b0;
      sclOe     <= 1'b0;
      byteStb   <= 1'b0;
      byteData  <= 8'h00;
      firstByte <= 1'b0;
      ackDone   <= 1'b0;
      startStb  <= 1'b0;
      stopStb   <= 1'b0;
    end
    else
    begin
      byteStb  <= 1'b0;
      ackDone  <= 1'b0;
      startStb <= isStart;
      stopStb  <= isStop;
      if (isStart || isStop)
      begin
        bitCnt_r  <= 4'h0;
        ackPh_r   <= 1'b0;
        sdaOe     <= 1'b0;
        inFirst_r <= isStart;
      end
      else if (sclRise && bitCnt_r != 4'h8)
      begin
        byteData <= {byteData[6:0], sdaS2_r};
        bitCnt_r <= bitCnt_r + 4'h1;
        if (bitCnt_r == 4'h7)
        begin
          byteStb   <= 1'b1;
          firstByte <= inFirst_r;
          inFirst_r <= 1'b0;
        end
      end
      else if (sclFall && bitCnt_r == 4'h8)
      begin
        if (!ackPh_r)
        begin
          ackPh_r <= 1'b1;
          sdaOe   <= ackReq;
        end
        else
        begin
          // Hold SCL low right as the acknowledge slot ends
          ackPh_r  <= 1'b0;
          sdaOe    <= 1'b0;
          bitCnt_r <= 4'h0;
          ackDone  <= 1'b1;
          if (holdReq)
            sclOe <= 1'b1;
        end
      end
      if (holdRel)
        sclOe <= 1'b0;
    end
  end
endmodule // ifp_i2c_rx

// ===== logic/ifp_map.vh
// Constants for the I2C flash program sequencer
`ifndef IFP_MAP_VH
`define IFP_MAP_VH
// Slave address byte, write direction, and mode code
`define IFP_SLV_WR      8'hA0
`define IFP_MODE_CODE   8'h00
// Command codes
`define IFP_CMD_BLK_ERW 8'h01
`define IFP_CMD_BYTE_PR 8'h02
`define IFP_CMD_BLK_CLR 8'h03
`define IFP_CMD_BYT_CLR 8'h04
`define IFP_CMD_ALL_CLR 8'h09
`define IFP_CMD_BLK_NER 8'h0B
`define IFP_CMD_SEL_PG  8'h0C
`define IFP_CMD_ADV_BLK 8'h0F
// Erase kinds on the memory port
`define IFP_KIND_ALL    2'h0
`define IFP_KIND_BLOCK  2'h1
`define IFP_KIND_BYTE   2'h2
// Pointer layout and limits
`define IFP_BLK_LAST    3'h7
`define IFP_SEQ_LASTPG  8'h1F
`define IFP_RST_PAGE    8'h30
`define IFP_RST_BLOCK   3'h3
`define IFP_BLK_BYTES   32
`define IFP_LAST_BYTE   5'h1F
// Clock rate and operation times
`define IFP_CLK_KHZ     10000
`define IFP_T_ERASE_US  2000
`define IFP_T_WRITE_US  2500
`define IFP_T_ERWR_US   4500
`define IFP_CYC(us)     (((us) * `IFP_CLK_KHZ) / 1000)
`endif

// ===== logic/ifp_seq.v
// Programming-mode command sequencer behind the I2C slave pins
// What this block does
// - Erase-all zeroes memory, holds SCL 2 ms
// - Erase-all also clears the lock state
// - No-erase block program takes 32 acked bytes
// - After byte 32, hold SCL 2.5 ms
// - Block pointer 0-7, wraps into next page
// - Select-page loads page from next byte
// - Byte program takes offset then data byte
// - Byte program holds SCL about 4.5 ms
// - Erasing block program: 32 bytes, 4.5 ms hold
// - Commands chain freely within one session
// - Byte and block clear zero their target
// - Increment past page 31 end wraps pointers to zero
// - Page 48 blocks 0-3 are writable
// - Entry: address 1010000 write, mode code zero
// - Decode the eight command byte codes
// - Block clear uses top 3 bits of byte
`include "ifp_map.vh"
module ifp_seq #(
  parameter T_ERASE_CYC = `IFP_CYC(`IFP_T_ERASE_US),
  parameter T_WRITE_CYC = `IFP_CYC(`IFP_T_WRITE_US),
  parameter T_ERWR_CYC  = `IFP_CYC(`IFP_T_ERWR_US)
) (
  input  wire        clock,
  input  wire        rstn,
  input  wire        sclIn,
  output wire        sclOut,
  output wire        sclOe,
  input  wire        sdaIn,
  output wire        sdaOut,
  output wire        sdaOe,
  output wire        nvmErase,
  output wire [1:0]  nvmEraseKind,
  output wire        nvmWr,
  output wire [15:0] nvmAddr,
  output wire [7:0]  nvmWdata,
  output wire        lockClr,
  output wire        busy,
  output wire        modeActive
);
  localparam [7:0] S_ADDR = 8'h01;
  localparam [7:0] S_MODE = 8'h02;
  localparam [7:0] S_CMD  = 8'h04;
  localparam [7:0] S_ARG1 = 8'h08;
  localparam [7:0] S_ARG2 = 8'h10;
  localparam [7:0] S_DATA = 8'h20;
  localparam [7:0] S_OP   = 8'h40;
  localparam [7:0] S_WAIT = 8'h80;

  reg  [7:0]  state_r;
  reg         modeOk_r;
  reg  [7:0]  cmd_r;
  reg  [7:0]  page_r;
  reg  [2:0]  block_r;
  reg  [4:0]  off_r;
  reg  [7:0]  arg_r;
  reg  [4:0]  cnt_r;
  reg         ackReq_r;
  reg         holdReq_r;
  reg         holdRel_r;
  reg  [15:0] timer_r;
  reg  [5:0]  idx_r;
  reg         rdPend_r;
  reg  [4:0]  rdIdx_r;
  reg         nvmErase_r;
  reg  [1:0]  nvmEraseKind_r;
  reg         nvmWr_r;
  reg  [15:0] nvmAddr_r;
  reg  [7:0]  nvmWdata_r;
  reg         lockClr_r;
  reg         busy_r;
  wire        byteStb;
  wire [7:0]  byteData;
  wire        firstByte;
  wire        ackDone;
  wire        startStb;
  wire        stopStb;
  wire [7:0]  bufRdData;
  wire        bufWe = byteStb && !firstByte && state_r == S_DATA;
  wire        streams;
  wire [10:0] advPtr;

  // Next page and block for one block advance
  function [10:0] nextPtr;
    input [7:0] pg;
    input [2:0] blk;
    begin
      if (blk != `IFP_BLK_LAST)
        nextPtr = {pg, blk + 3'h1};
      else if (pg >= `IFP_SEQ_LASTPG)
        nextPtr = 11'h000;
      else
        nextPtr = {pg + 8'h01, 3'h0};
    end
  endfunction

  // Absolute memory address from page, block, offset
  function [15:0] absAddr;
    input [7:0] pg;
    input [2:0] blk;
    input [4:0] off;
    begin
      absAddr = {pg, blk, off};
    end
  endfunction

  assign advPtr  = nextPtr(page_r, block_r);
  assign streams = cmd_r == `IFP_CMD_BLK_ERW || cmd_r == `IFP_CMD_BLK_NER;

  ifp_i2c_rx u_rx (
    .clock     (clock),
    .rstn      (rstn),
    .sclIn     (sclIn),
    .sdaIn     (sdaIn),
    .ackReq    (ackReq_r),
    .holdReq   (holdReq_r),
    .holdRel   (holdRel_r),
    .sdaOe     (sdaOe),
    .sclOe     (sclOe),
    .byteStb   (byteStb),
    .byteData  (byteData),
    .firstByte (firstByte),
    .ackDone   (ackDone),
    .startStb  (startStb),
    .stopStb   (stopStb)
  );

  ifp_buf #(
    .WIDTH (8),
    .DEPTH (`IFP_BLK_BYTES),
    .AW    (5)
  ) u_buf (
    .clock  (clock),
    .we     (bufWe),
    .wrAddr (cnt_r),
    .wrData (byteData),
    .rdAddr (idx_r[4:0]),
    .rdData (bufRdData)
  );

  // Pins only ever pull low
  assign sclOut       = 1'b0;
  assign sdaOut       = 1'b0;
  assign nvmErase     = nvmErase_r;
  assign nvmEraseKind = nvmEraseKind_r;
  assign nvmWr        = nvmWr_r;
  assign nvmAddr      = nvmAddr_r;
  assign nvmWdata     = nvmWdata_r;
  assign lockClr      = lockClr_r;
  assign busy         = busy_r;
  assign modeActive   = modeOk_r;

  // Command decoding, pointers and operation sequencing
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r        <= S_ADDR;
      modeOk_r       <= 1'b0;
      cmd_r          <= 8'h00;
      page_r         <= `IFP_RST_PAGE;
      block_r        <= `IFP_RST_BLOCK;
      off_r          <= 5'h00;
      arg_r          <= 8'h00;
      cnt_r          <= 5'h00;
      ackReq_r       <= 1'b0;
      holdReq_r      <= 1'b0;
      holdRel_r      <= 1'b0;
      timer_r        <= 16'h0000;
      idx_r          <= 6'h00;
      rdPend_r       <= 1'b0;
      rdIdx_r        <= 5'h00;
      nvmErase_r     <= 1'b0;
      nvmEraseKind_r <= `IFP_KIND_ALL;
      nvmWr_r        <= 1'b0;
      nvmAddr_r      <= 16'h0000;
      nvmWdata_r     <= 8'h00;
      lockClr_r      <= 1'b0;
      busy_r         <= 1'b0;
    end
    else
    begin
      nvmErase_r <= 1'b0;
      nvmWr_r    <= 1'b0;
      lockClr_r  <= 1'b0;
      holdRel_r  <= 1'b0;
      if (ackDone)
        ackReq_r <= 1'b0;
      case (state_r)
        S_OP, S_WAIT:
        begin
          timer_r <= timer_r - 16'h0001;
          rdPend_r <= 1'b0;
          if (state_r == S_OP && streams && idx_r != 6'h20)
          begin
            rdPend_r <= 1'b1;
            rdIdx_r  <= idx_r[4:0];
            idx_r    <= idx_r + 6'h01;
          end
          // byte-by-byte write of the buffered block, one byte per cycle
          if (rdPend_r)
          begin
            nvmWr_r    <= 1'b1;
            nvmAddr_r  <= absAddr(page_r, block_r, rdIdx_r);
            nvmWdata_r <= bufRdData;
          end
          // single byte write after its erase
          if (state_r == S_OP && cmd_r == `IFP_CMD_BYTE_PR)
          begin
            nvmWr_r    <= 1'b1;
            nvmAddr_r  <= absAddr(page_r, block_r, off_r);
            nvmWdata_r <= arg_r;
          end
          if (state_r == S_OP && !rdPend_r
              && (!streams || idx_r == 6'h20))
            state_r <= S_WAIT;
          if (state_r == S_WAIT && timer_r == 16'h0000)
          begin
            holdRel_r <= 1'b1;
            busy_r    <= 1'b0;
            state_r   <= S_CMD;
          end
        end
        default:
        begin
          if (ackDone && holdReq_r)
          begin
            holdReq_r <= 1'b0;
            busy_r    <= 1'b1;
            idx_r     <= 6'h00;
            state_r   <= S_OP;
            case (cmd_r)
              `IFP_CMD_ALL_CLR:
              begin
                nvmErase_r     <= 1'b1;
                nvmEraseKind_r <= `IFP_KIND_ALL;
                nvmAddr_r      <= 16'h0000;
                lockClr_r      <= 1'b1;
                timer_r        <= T_ERASE_CYC[15:0];
              end
              `IFP_CMD_BLK_CLR, `IFP_CMD_BLK_ERW:
              begin
                nvmErase_r     <= 1'b1;
                nvmEraseKind_r <= `IFP_KIND_BLOCK;
                nvmAddr_r      <= absAddr(page_r, block_r, 5'h00);
                if (cmd_r == `IFP_CMD_BLK_ERW)
                  timer_r <= T_ERWR_CYC[15:0];
                else
                  timer_r <= T_ERASE_CYC[15:0];
              end
              `IFP_CMD_BYT_CLR, `IFP_CMD_BYTE_PR:
              begin
                nvmErase_r     <= 1'b1;
                nvmEraseKind_r <= `IFP_KIND_BYTE;
                nvmAddr_r      <= absAddr(page_r, block_r, off_r);
                if (cmd_r == `IFP_CMD_BYTE_PR)
                  timer_r <= T_ERWR_CYC[15:0];
                else
                  timer_r <= T_ERASE_CYC[15:0];
              end
              default:
              begin
                timer_r <= T_WRITE_CYC[15:0];
              end
            endcase
          end
          else if (stopStb)
          begin
            holdReq_r <= 1'b0;
            state_r   <= S_ADDR;
          end
          else if (byteStb && firstByte)
          begin
            if (byteData == `IFP_SLV_WR)
            begin
              ackReq_r <= 1'b1;
              state_r  <= modeOk_r ? S_CMD : S_MODE;
            end
            else
              state_r <= S_ADDR;
          end
          else if (byteStb)
          begin
            case (state_r)
              S_MODE:
              begin
                if (byteData == `IFP_MODE_CODE)
                begin
                  ackReq_r <= 1'b1;
                  modeOk_r <= 1'b1;
                  state_r  <= S_CMD;
                end
                else
                  state_r <= S_ADDR;
              end
              S_CMD:
              begin
                cmd_r <= byteData;
                case (byteData)
                  `IFP_CMD_ADV_BLK:
                  begin
                    // wrap to zero past page 31
                    ackReq_r <= 1'b1;
                    page_r   <= advPtr[10:3];
                    block_r  <= advPtr[2:0];
                    off_r    <= 5'h00;
                  end
                  `IFP_CMD_ALL_CLR:
                  begin
                    ackReq_r  <= 1'b1;
                    holdReq_r <= 1'b1;
                  end
                  `IFP_CMD_SEL_PG, `IFP_CMD_BYTE_PR,
                  `IFP_CMD_BLK_CLR, `IFP_CMD_BYT_CLR:
                  begin
                    ackReq_r <= 1'b1;
                    state_r  <= S_ARG1;
                  end
                  `IFP_CMD_BLK_ERW, `IFP_CMD_BLK_NER:
                  begin
                    ackReq_r <= 1'b1;
                    cnt_r    <= 5'h00;
                    state_r  <= S_DATA;
                  end
                  default:
                    ackReq_r <= 1'b0;
                endcase
              end
              S_ARG1:
              begin
                ackReq_r <= 1'b1;
                if (cmd_r == `IFP_CMD_SEL_PG)
                begin
                  // page from next byte, any page
                  page_r  <= byteData;
                  block_r <= 3'h0;
                  off_r   <= 5'h00;
                  state_r <= S_CMD;
                end
                else
                begin
                  block_r <= byteData[7:5];
                  off_r   <= (cmd_r == `IFP_CMD_BLK_CLR) ? 5'h00
                                                         : byteData[4:0];
                  if (cmd_r == `IFP_CMD_BYTE_PR)
                    state_r <= S_ARG2;
                  else
                  begin
                    holdReq_r <= 1'b1;
                    state_r   <= S_CMD;
                  end
                end
              end
              S_ARG2:
              begin
                ackReq_r  <= 1'b1;
                arg_r     <= byteData;
                holdReq_r <= 1'b1;
                state_r   <= S_CMD;
              end
              S_DATA:
              begin
                ackReq_r <= 1'b1;
                cnt_r    <= cnt_r + 5'h01;
                if (cnt_r == `IFP_LAST_BYTE)
                begin
                  holdReq_r <= 1'b1;
                  state_r   <= S_CMD;
                end
              end
              default:
                ackReq_r <= 1'b0;
            endcase
          end
        end
      endcase
    end
  end
endmodule // ifp_seq
